// ===== core/ldi_pkg.sv
// Contract
// - CKE high runs clocks, buffers, drivers.
// - CKE low enters precharge/active power-down, self refresh.
// - CKE sampled on clock; self refresh exit asynchronous.
// - Power-down disables inputs except clock and CKE.
// - Strobe edge-aligned on reads, centred on writes.
// - Lower strobe bits 0-7, upper bits 8-15.
// - Controller holds CKE high during power-up.
// - Clock starts after supply good, CKE high.
// - 200 us of NOP clocks before commands.
// - Precharge-all is first init command.
// - Precharge period of NOPs after precharge-all.
// - Two auto refreshes, each then refresh time.
// - Refreshes early or after second mode wait.
// - Program base mode register, then mode delay.
// - Program extended mode register; either order.
// - Both mode registers programmed during init.
// - Clock not stopped before init completes.
// - Device accepts commands after final mode delay.
// - Power interruption restarts full initialisation.
// - Mode set with bank zero selects base.
// - Chip select high ignores every command.
package ldi_pkg;
	localparam int CLK_PERIOD_PS         = 4000;
	localparam int LINK_DIV              = 2;
	localparam int LINK_PERIOD_PS        = CLK_PERIOD_PS * LINK_DIV;
	localparam int STARTUP_WAIT_US       = 200;
	localparam int PRECHARGE_PERIOD_NS   = 20;
	localparam int REFRESH_CYCLE_TIME_NS = 80;
	localparam int MODE_SET_DELAY_NS     = 10;

	function automatic int ldi_cycles(input int t_ps, input int per_ps);
		int n;
		n = (t_ps + per_ps - 1) / per_ps;
		return (n < 1) ? 1 : n;
	endfunction

	localparam int STARTUP_CYCLES   = ldi_cycles(STARTUP_WAIT_US * 1000000, CLK_PERIOD_PS);
	localparam int PRECHARGE_CYCLES = ldi_cycles(PRECHARGE_PERIOD_NS * 1000, CLK_PERIOD_PS);
	localparam int REFRESH_CYCLES   = ldi_cycles(REFRESH_CYCLE_TIME_NS * 1000, CLK_PERIOD_PS);
	localparam int MODE_SET_CYCLES  = ldi_cycles(MODE_SET_DELAY_NS * 1000, CLK_PERIOD_PS);
	localparam int MODE_SET_LINK    = ldi_cycles(MODE_SET_DELAY_NS * 1000, LINK_PERIOD_PS);

	localparam int WAIT_W = 20;
	localparam int ADDR_W = 14;
	localparam int BA_W   = 2;
	localparam int BANKS  = 4;
	localparam int DQ_W   = 16;
	localparam int LANE_W = 8;
	localparam int LANES  = 2;
	localparam int MEM_AW = 4;
	localparam int AP_BIT = 10;

	typedef logic [3:0] ldi_cmd_t;
	localparam ldi_cmd_t CMD_MRS   = 4'h0;
	localparam ldi_cmd_t CMD_REF   = 4'h1;
	localparam ldi_cmd_t CMD_PRE   = 4'h2;
	localparam ldi_cmd_t CMD_ACT   = 4'h3;
	localparam ldi_cmd_t CMD_WRITE = 4'h4;
	localparam ldi_cmd_t CMD_READ  = 4'h5;
	localparam ldi_cmd_t CMD_NOP   = 4'h7;

	localparam logic [BA_W-1:0]   BA_BASE_MODE   = 2'h0;
	localparam logic [BA_W-1:0]   BA_EXT_MODE    = 2'h2;
	localparam logic [ADDR_W-1:0] ADDR_ALL_BANKS = 14'h0400;
	localparam logic [1:0]        REF_INIT_COUNT = 2'h2;

	localparam logic [3:0] WR_DATA_ON  = 4'h2;
	localparam logic [3:0] WR_STROBE   = 4'h4;
	localparam logic [3:0] WR_DATA_OFF = 4'h6;
	localparam logic [3:0] RD_DONE     = 4'h8;
	localparam logic [1:0] RD_HOLD_CK  = 2'h2;
	localparam logic [1:0] WR_WIN_CK   = 2'h2;

	// Chip select high is a deselect whatever the other pins say
	function automatic logic ldi_is_idle(input ldi_cmd_t c);
		return c[3] || (c == CMD_NOP);
	endfunction
endpackage

// ===== core/ldi_link_if.sv
`timescale 1ns/1ps
interface ldi_link_if
	import ldi_pkg::*;
;
	logic                ck;
	logic                cke;
	logic                cs_n;
	logic                ras_n;
	logic                cas_n;
	logic                we_n;
	logic [BA_W-1:0]     ba;
	logic [ADDR_W-1:0]   addr;
	logic [LANES-1:0]    dm;
	logic [DQ_W-1:0]     dq_c;
	logic                dq_c_oe_n;
	logic [DQ_W-1:0]     dq_d;
	logic                dq_d_oe_n;
	logic [LANES-1:0]    dqs_c;
	logic                dqs_c_oe_n;
	logic [LANES-1:0]    dqs_d;
	logic                dqs_d_oe_n;
	logic [DQ_W-1:0]     dq;
	logic [LANES-1:0]    dqs;

	// Undriven wire resolves to the device value instead of floating
	assign dq  = dq_c_oe_n ? dq_d : dq_c;
	assign dqs = dqs_c_oe_n ? dqs_d : dqs_c;

	modport ctrl (
		output ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr, dm,
		output dq_c, dq_c_oe_n, dqs_c, dqs_c_oe_n,
		input  dq, dqs
	);
	modport dev (
		input  ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr, dm,
		output dq_d, dq_d_oe_n, dqs_d, dqs_d_oe_n,
		input  dq, dqs
	);
endinterface

// ===== core/ldi_dev_end.sv
`timescale 1ns/1ps
module ldi_dev_end
	import ldi_pkg::*;
(
	input  wire logic              nrst_in,
	ldi_link_if.dev                lk,
	output logic                   init_done_out,
	output logic [3:0]             power_state_out,
	output logic [ADDR_W-1:0]      base_mode_out,
	output logic [ADDR_W-1:0]      ext_mode_out,
	output logic [BANKS-1:0]       open_banks_out
);
	typedef enum logic [3:0] {
		DS_RUN      = 4'h1,
		DS_PD_PRE   = 4'h2,
		DS_PD_ACT   = 4'h4,
		DS_SELF_REF = 4'h8
	} ldi_dst_t;

	ldi_dst_t          st;
	ldi_cmd_t          cmd;
	logic              cke_q;
	logic              cmd_en;
	logic              user_en;
	logic              pre_seen;
	logic [1:0]        ref_cnt;
	logic              base_set;
	logic              ext_set;
	logic [3:0]        msd_cnt;
	logic              wake_tgl;
	logic              wake_s1;
	logic              wake_s2;
	logic              wake_s3;
	logic [1:0]        rd_cnt;
	logic [1:0]        wr_win;
	logic [MEM_AW-1:0] wr_col;
	logic [LANES-1:0]  dqs_prev;
	logic [DQ_W-1:0]   mem [2**MEM_AW];

	assign cmd = {lk.cs_n, lk.ras_n, lk.cas_n, lk.we_n};
	assign cmd_en = (st == DS_RUN) && cke_q && lk.cke && !ldi_is_idle(cmd);
	assign user_en = cmd_en && init_done_out;
	assign power_state_out = st;
	assign lk.dq_d_oe_n = !((rd_cnt != 2'h0) && lk.cke);
	assign lk.dqs_d_oe_n = lk.dq_d_oe_n;

	always_ff @(posedge lk.ck or negedge nrst_in) begin
		if (!nrst_in) begin
			cke_q <= 1'b1;
		end else begin
			cke_q <= lk.cke;
		end
	end

	// Wake edge caught without the link clock, which may be stopped
	always_ff @(posedge lk.cke or negedge nrst_in) begin
		if (!nrst_in) begin
			wake_tgl <= 1'b0;
		end else begin
			wake_tgl <= ~wake_tgl;
		end
	end

	always_ff @(posedge lk.ck or negedge nrst_in) begin
		if (!nrst_in) begin
			wake_s1 <= 1'b0;
			wake_s2 <= 1'b0;
			wake_s3 <= 1'b0;
		end else begin
			wake_s1 <= wake_tgl;
			wake_s2 <= wake_s1;
			wake_s3 <= wake_s2;
		end
	end

	always_ff @(posedge lk.ck or negedge nrst_in) begin
		if (!nrst_in) begin
			pre_seen      <= 1'b0;
			ref_cnt       <= 2'h0;
			base_set      <= 1'b0;
			ext_set       <= 1'b0;
			msd_cnt       <= 4'h0;
			base_mode_out <= '0;
			ext_mode_out  <= '0;
			init_done_out <= 1'b0;
		end else begin
			if (cmd_en && cmd == CMD_PRE && lk.addr[AP_BIT]) begin
				pre_seen <= 1'b1;
			end
			if (cmd_en && cmd == CMD_REF && pre_seen && ref_cnt != REF_INIT_COUNT) begin
				ref_cnt <= ref_cnt + 2'h1;
			end
			if (cmd_en && cmd == CMD_MRS) begin
				msd_cnt <= 4'(MODE_SET_LINK);
				if (lk.ba == BA_BASE_MODE) begin
					base_mode_out <= lk.addr;
					base_set      <= 1'b1;
				end else if (lk.ba == BA_EXT_MODE) begin
					ext_mode_out <= lk.addr;
					ext_set      <= 1'b1;
				end
			end else if (msd_cnt != 4'h0) begin
				msd_cnt <= msd_cnt - 4'h1;
			end
			// Ready as the last delay count expires, ahead of the first user slot
			if (pre_seen && ref_cnt == REF_INIT_COUNT && base_set && ext_set
					&& msd_cnt <= 4'h1) begin
				init_done_out <= 1'b1;
			end
		end
	end

	always_ff @(posedge lk.ck or negedge nrst_in) begin
		if (!nrst_in) begin
			open_banks_out <= '0;
		end else if (user_en && cmd == CMD_ACT) begin
			open_banks_out[lk.ba] <= 1'b1;
		end else if (user_en && cmd == CMD_PRE) begin
			if (lk.addr[AP_BIT]) begin
				open_banks_out <= '0;
			end else begin
				open_banks_out[lk.ba] <= 1'b0;
			end
		end
	end

	always_ff @(posedge lk.ck or negedge nrst_in) begin
		if (!nrst_in) begin
			st <= DS_RUN;
		end else begin
			unique case (st)
				DS_RUN: begin
					if (cke_q && !lk.cke && init_done_out) begin
						if (cmd == CMD_REF) begin
							st <= DS_SELF_REF;
						end else if (open_banks_out != '0) begin
							st <= DS_PD_ACT;
						end else begin
							st <= DS_PD_PRE;
						end
					end
				end
				DS_PD_PRE, DS_PD_ACT: begin
					if (lk.cke) begin
						st <= DS_RUN;
					end
				end
				DS_SELF_REF: begin
					// A stale wake edge from a power-down exit must not end self refresh
					if (wake_s2 != wake_s3 && lk.cke) begin
						st <= DS_RUN;
					end
				end
			endcase
		end
	end

	// Read data and both strobes launch on the same edge
	always_ff @(posedge lk.ck or negedge nrst_in) begin
		if (!nrst_in) begin
			rd_cnt   <= 2'h0;
			lk.dq_d  <= '0;
			lk.dqs_d <= '0;
		end else if (user_en && cmd == CMD_READ) begin
			rd_cnt   <= RD_HOLD_CK;
			lk.dq_d  <= mem[lk.addr[MEM_AW-1:0]];
			lk.dqs_d <= ~lk.dqs_d;
		end else if (rd_cnt != 2'h0) begin
			rd_cnt <= rd_cnt - 2'h1;
		end
	end

	always_ff @(posedge lk.ck or negedge nrst_in) begin
		if (!nrst_in) begin
			wr_win   <= 2'h0;
			wr_col   <= '0;
			dqs_prev <= '0;
		end else begin
			dqs_prev <= lk.dqs;
			if (user_en && cmd == CMD_WRITE) begin
				wr_win <= WR_WIN_CK;
				wr_col <= lk.addr[MEM_AW-1:0];
			end else if (wr_win != 2'h0) begin
				wr_win <= wr_win - 2'h1;
			end
		end
	end

	// Each lane is written only on its own strobe edge
	always_ff @(posedge lk.ck) begin
		for (int i = 0; i < LANES; i++) begin
			if (wr_win != 2'h0 && cke_q && lk.dqs[i] != dqs_prev[i] && !lk.dm[i]) begin
				mem[wr_col][i*LANE_W +: LANE_W] <= lk.dq[i*LANE_W +: LANE_W];
			end
		end
	end
endmodule

// ===== core/ldi_ctrl_end.sv
`timescale 1ns/1ps
module ldi_ctrl_end
	import ldi_pkg::*;
#(
	parameter int STARTUP_WAIT_CYCLES = STARTUP_CYCLES,
	parameter bit LATE_REFRESH        = 1'b0,
	parameter bit EXT_MODE_FIRST      = 1'b0
) (
	input  wire logic              clk_in,
	input  wire logic              nrst_in,
	ldi_link_if.ctrl               lk,
	input  wire logic              supply_good_in,
	input  wire logic              restart_in,
	input  wire logic              clock_stop_in,
	input  wire logic              user_cke_in,
	input  wire logic              cmd_valid_in,
	input  wire ldi_cmd_t          cmd_in,
	input  wire logic [BA_W-1:0]   ba_in,
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic [DQ_W-1:0]   wdata_in,
	input  wire logic [LANES-1:0]  wmask_in,
	input  wire logic [ADDR_W-1:0] base_mode_in,
	input  wire logic [ADDR_W-1:0] ext_mode_in,
	output logic                   cmd_ready_out,
	output logic                   init_done_out,
	output logic [DQ_W-1:0]        rdata_out,
	output logic                   rdata_valid_out
);
	typedef enum logic [6:0] {
		ST_POWER  = 7'h01,
		ST_START  = 7'h02,
		ST_PRE    = 7'h04,
		ST_REF    = 7'h08,
		ST_MODE_A = 7'h10,
		ST_MODE_B = 7'h20,
		ST_READY  = 7'h40
	} ldi_cst_t;

	ldi_cst_t            st;
	ldi_cst_t            next_st;
	ldi_cmd_t            next_cmd;
	logic [BA_W-1:0]     next_ba;
	logic [ADDR_W-1:0]   next_addr;
	logic [WAIT_W-1:0]   next_wait;
	logic [WAIT_W-1:0]   wait_cnt;
	logic                sup_s1;
	logic                sup_s2;
	logic                fail;
	logic                ck_run;
	logic                slot;
	logic                sent;
	logic                ref_second;
	logic                issue_now;
	logic                accept;
	logic                data_cmd;
	logic [3:0]          dcnt;
	logic                dwrite;
	logic [DQ_W-1:0]     wdata_q;
	logic [LANES-1:0]    wmask_q;
	logic [DQ_W-1:0]     dq_s1;
	logic [DQ_W-1:0]     dq_s2;
	logic [LANES-1:0]    dqs_s1;
	logic [LANES-1:0]    dqs_s2;
	logic [LANES-1:0]    dqs_s3;

	// Pins change only while the link clock falls, so the device never races
	assign slot = ck_run && lk.ck;
	assign fail = restart_in || !sup_s2;
	assign init_done_out = (st == ST_READY);
	assign cmd_ready_out = init_done_out && slot && (dcnt == 4'h0);
	assign accept = cmd_valid_in && cmd_ready_out;
	assign data_cmd = (cmd_in == CMD_WRITE) || (cmd_in == CMD_READ);
	assign issue_now = !sent && slot
		&& (st == ST_PRE || st == ST_REF || st == ST_MODE_A || st == ST_MODE_B);

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sup_s1 <= 1'b0;
			sup_s2 <= 1'b0;
		end else begin
			sup_s1 <= supply_good_in;
			sup_s2 <= sup_s1;
		end
	end

	always_comb begin
		next_cmd  = CMD_NOP;
		next_ba   = '0;
		next_addr = '0;
		next_wait = '0;
		next_st   = st;
		unique case (st)
			ST_POWER: begin
				next_st = ST_START;
			end
			ST_START: begin
				next_st = ST_PRE;
			end
			ST_PRE: begin
				next_cmd  = CMD_PRE;
				next_addr = ADDR_ALL_BANKS;
				next_wait = WAIT_W'(PRECHARGE_CYCLES);
				next_st   = LATE_REFRESH ? ST_MODE_A : ST_REF;
			end
			ST_REF: begin
				next_cmd  = CMD_REF;
				next_wait = WAIT_W'(REFRESH_CYCLES);
				next_st   = LATE_REFRESH ? ST_READY : ST_MODE_A;
			end
			ST_MODE_A: begin
				next_cmd  = CMD_MRS;
				next_ba   = EXT_MODE_FIRST ? BA_EXT_MODE : BA_BASE_MODE;
				next_addr = EXT_MODE_FIRST ? ext_mode_in : base_mode_in;
				next_wait = WAIT_W'(MODE_SET_CYCLES);
				next_st   = ST_MODE_B;
			end
			ST_MODE_B: begin
				next_cmd  = CMD_MRS;
				next_ba   = EXT_MODE_FIRST ? BA_BASE_MODE : BA_EXT_MODE;
				next_addr = EXT_MODE_FIRST ? base_mode_in : ext_mode_in;
				next_wait = WAIT_W'(MODE_SET_CYCLES);
				next_st   = LATE_REFRESH ? ST_REF : ST_READY;
			end
			ST_READY: begin
				next_cmd  = cmd_in;
				next_ba   = ba_in;
				next_addr = addr_in;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wait_cnt <= '0;
		end else if (fail) begin
			wait_cnt <= '0;
		end else if (st == ST_POWER) begin
			wait_cnt <= WAIT_W'(STARTUP_WAIT_CYCLES);
		end else if (issue_now) begin
			wait_cnt <= next_wait;
		end else if (wait_cnt != '0) begin
			wait_cnt <= wait_cnt - 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st         <= ST_POWER;
			sent       <= 1'b0;
			ref_second <= 1'b0;
		end else if (fail) begin
			st         <= ST_POWER;
			sent       <= 1'b0;
			ref_second <= 1'b0;
		end else begin
			unique case (st)
				ST_POWER: begin
					st <= next_st;
				end
				ST_START: begin
					if (wait_cnt == '0) begin
						st <= next_st;
					end
				end
				ST_PRE, ST_REF, ST_MODE_A, ST_MODE_B: begin
					if (issue_now) begin
						sent <= 1'b1;
					end else if (sent && wait_cnt == '0) begin
						sent <= 1'b0;
						if (st == ST_REF && !ref_second) begin
							ref_second <= 1'b1;
						end else begin
							ref_second <= 1'b0;
							st         <= next_st;
						end
					end
				end
				ST_READY: begin
					st <= ST_READY;
				end
			endcase
		end
	end

	// Divided link clock; a high phase always completes before a stop
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ck_run <= 1'b0;
			lk.ck  <= 1'b0;
		end else begin
			ck_run <= !fail && st != ST_POWER && !(init_done_out && clock_stop_in);
			lk.ck  <= (ck_run || lk.ck) ? ~lk.ck : 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			lk.cke <= 1'b1;
		end else if (fail) begin
			lk.cke <= 1'b1;
		end else if (slot) begin
			lk.cke <= init_done_out ? user_cke_in : 1'b1;
		end
	end

	// Outside the issue slots the bus carries only NOP
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			{lk.cs_n, lk.ras_n, lk.cas_n, lk.we_n} <= CMD_NOP;
			lk.ba   <= '0;
			lk.addr <= '0;
		end else if (slot) begin
			{lk.cs_n, lk.ras_n, lk.cas_n, lk.we_n} <= (issue_now || accept) ? next_cmd : CMD_NOP;
			lk.ba   <= next_ba;
			lk.addr <= next_addr;
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			dcnt    <= 4'h0;
			dwrite  <= 1'b0;
			wdata_q <= '0;
			wmask_q <= '0;
		end else if (fail) begin
			dcnt <= 4'h0;
		end else if (accept && data_cmd) begin
			dcnt    <= 4'h1;
			dwrite  <= (cmd_in == CMD_WRITE);
			wdata_q <= wdata_in;
			wmask_q <= wmask_in;
		end else if (dcnt != 4'h0) begin
			dcnt <= (dcnt == (dwrite ? WR_DATA_OFF : RD_DONE)) ? 4'h0 : dcnt + 4'h1;
		end
	end

	// Strobe flips midway through the two-cycle data window
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			lk.dq_c       <= '0;
			lk.dq_c_oe_n  <= 1'b1;
			lk.dqs_c      <= '0;
			lk.dqs_c_oe_n <= 1'b1;
			lk.dm         <= '0;
		end else if (dwrite && dcnt == WR_DATA_ON) begin
			lk.dq_c       <= wdata_q;
			lk.dm         <= wmask_q;
			lk.dq_c_oe_n  <= 1'b0;
			lk.dqs_c_oe_n <= 1'b0;
		end else if (dwrite && dcnt == WR_STROBE) begin
			lk.dqs_c <= ~lk.dqs_c;
		end else if (dcnt == WR_DATA_OFF || fail) begin
			lk.dq_c_oe_n  <= 1'b1;
			lk.dqs_c_oe_n <= 1'b1;
			lk.dm         <= '0;
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			dq_s1  <= '0;
			dq_s2  <= '0;
			dqs_s1 <= '0;
			dqs_s2 <= '0;
			dqs_s3 <= '0;
		end else begin
			dq_s1  <= lk.dq;
			dq_s2  <= dq_s1;
			dqs_s1 <= lk.dqs;
			dqs_s2 <= dqs_s1;
			dqs_s3 <= dqs_s2;
		end
	end

	// Each byte is taken on its own strobe edge
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rdata_out       <= '0;
			rdata_valid_out <= 1'b0;
		end else begin
			rdata_valid_out <= !dwrite && dcnt != 4'h0 && dqs_s2[0] != dqs_s3[0];
			for (int i = 0; i < LANES; i++) begin
				if (!dwrite && dcnt != 4'h0 && dqs_s2[i] != dqs_s3[i]) begin
					rdata_out[i*LANE_W +: LANE_W] <= dq_s2[i*LANE_W +: LANE_W];
				end
			end
		end
	end
endmodule

// ===== testbench/ldi_properties.sv
`timescale 1ns/1ps
module ldi_properties
	import ldi_pkg::*;
#(
	parameter int STARTUP_WAIT_CYCLES = 40
) (
	input  wire logic              clk_in,
	input  wire logic              nrst_in,
	input  wire logic              ck,
	input  wire logic              cke,
	input  wire logic              cs_n,
	input  wire logic              ras_n,
	input  wire logic              cas_n,
	input  wire logic              we_n,
	input  wire logic [BA_W-1:0]   ba,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [LANES-1:0]  dm,
	input  wire logic              dq_c_oe_n,
	input  wire logic              dqs_c_oe_n,
	input  wire logic              dq_d_oe_n,
	input  wire logic              dqs_d_oe_n
);
	ldi_cmd_t    cmd;
	ldi_cmd_t    last_cmd;
	logic        ck_q;
	logic        ck_on;
	logic        issue;
	logic        base_seen;
	logic        ext_seen;
	logic [2:0]  step;
	logic [1:0]  ref_cnt;
	logic [15:0] gap;
	logic [15:0] run;

	assign cmd   = {cs_n, ras_n, cas_n, we_n};
	// Commands launch on the clk edge where ck falls
	assign issue = ck_q && !ck && !cs_n && (cmd != CMD_NOP);

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ck_q  <= 1'b0;
			ck_on <= 1'b0;
			run   <= 16'h0;
		end else begin
			ck_q  <= ck;
			ck_on <= ck_on || ck;
			if (ck_on && step == 3'h0 && run != 16'hffff)
				run <= run + 16'h1;
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			step     <= 3'h0;
			gap      <= 16'h0;
			last_cmd <= CMD_NOP;
		end else begin
			if (gap != 16'hffff)
				gap <= gap + 16'h1;
			if (issue) begin
				gap      <= 16'h1;
				last_cmd <= cmd;
				if (step != 3'h6)
					step <= step + 3'h1;
			end
		end
	end

	// Only the first five commands after reset are the init sequence
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ref_cnt   <= 2'h0;
			base_seen <= 1'b0;
			ext_seen  <= 1'b0;
		end else if (issue && step < 3'h5) begin
			if (cmd == CMD_REF)
				ref_cnt <= ref_cnt + 2'h1;
			if (cmd == CMD_MRS && ba == BA_BASE_MODE)
				base_seen <= 1'b1;
			if (cmd == CMD_MRS && ba == BA_EXT_MODE)
				ext_seen <= 1'b1;
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);

	sequence s_cmd(ldi_cmd_t c);
		issue && cmd == c;
	endsequence
	sequence s_after(ldi_cmd_t c);
		issue && step != 3'h0 && step <= 3'h5 && last_cmd == c;
	endsequence

	a_cke_held_high: assert property (step < 3'h5 |-> cke)
		else $error("clock enable low during init");
	a_clock_first_rise: assert property (ck && !ck_on |-> cke)
		else $error("link clock started with clock enable low");
	a_startup_nop_wait: assert property (issue && step == 3'h0 |-> run >= STARTUP_WAIT_CYCLES - 4)
		else $error("command before startup wait ended");
	a_first_precharge: assert property (issue && step == 3'h0 |-> cmd == CMD_PRE && addr[AP_BIT])
		else $error("first command not precharge all");
	a_precharge_gap: assert property (s_after(CMD_PRE) |-> gap >= PRECHARGE_CYCLES)
		else $error("precharge period too short");
	a_refresh_gap: assert property (s_after(CMD_REF) |-> gap >= REFRESH_CYCLES)
		else $error("refresh cycle time too short");
	a_mode_set_gap: assert property (s_after(CMD_MRS) |-> gap >= MODE_SET_CYCLES)
		else $error("mode set delay too short");
	a_init_complete: assert property (issue && step == 3'h5 |-> ref_cnt == REF_INIT_COUNT && base_seen && ext_seen)
		else $error("init sequence incomplete");
	a_clock_runs_init: assert property (ck_on && step < 3'h5 |-> ck != $past(ck))
		else $error("link clock stalled during init");
	a_write_owner: assert property (!dq_c_oe_n |-> !dqs_c_oe_n && dq_d_oe_n)
		else $error("write strobe or bus ownership wrong");
	a_mask_window: assert property (dm != 2'h0 |-> !dq_c_oe_n)
		else $error("data mask outside write window");
	a_read_start: assert property (s_cmd(CMD_READ) |-> ##[1:3] (!dq_d_oe_n && !dqs_d_oe_n))
		else $error("read data and strobe not driven");
	a_read_release: assert property ($fell(dq_d_oe_n) |-> ##[1:8] dq_d_oe_n)
		else $error("read drive not released");
endmodule

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top
	import ldi_pkg::*;
;
	localparam int SW = 40;
	logic              clk_in = 1'b0;
	logic              nrst_in = 1'b1;
	logic              supply_good_in = 1'b1;
	logic              restart_in = 1'b0;
	logic              clock_stop_in = 1'b0;
	logic              user_cke_in = 1'b1;
	logic              cmd_valid_in = 1'b0;
	ldi_cmd_t          cmd_in = CMD_NOP;
	logic [ADDR_W-1:0] addr_in = 14'h0;
	logic [DQ_W-1:0]   wdata_in = 16'h0;
	logic [LANES-1:0]  wmask_in = 2'h0;
	logic [ADDR_W-1:0] base_mode_in = 14'h0032;
	logic [ADDR_W-1:0] ext_mode_in = 14'h0004;
	logic              cmd_ready_out;
	logic              c_done;
	logic              d_done;
	logic              rdata_valid_out;
	logic              ck_seen;
	logic [DQ_W-1:0]   rdata_out;
	logic [3:0]        pstate;
	logic [ADDR_W-1:0] base_q;
	logic [ADDR_W-1:0] ext_q;
	logic [BANKS-1:0]  banks;
	int                fail_count = 0;
	int                n_compared = 0;

	always #2 clk_in = ~clk_in;

	ldi_link_if lk ();
	ldi_ctrl_end #(.STARTUP_WAIT_CYCLES(SW)) i_ldi_ctrl_end (.clk_in(clk_in), .nrst_in(nrst_in),
		.lk(lk), .supply_good_in(supply_good_in), .restart_in(restart_in),
		.clock_stop_in(clock_stop_in), .user_cke_in(user_cke_in), .cmd_valid_in(cmd_valid_in),
		.cmd_in(cmd_in), .ba_in(2'h0), .addr_in(addr_in), .wdata_in(wdata_in),
		.wmask_in(wmask_in), .base_mode_in(base_mode_in), .ext_mode_in(ext_mode_in),
		.cmd_ready_out(cmd_ready_out), .init_done_out(c_done), .rdata_out(rdata_out),
		.rdata_valid_out(rdata_valid_out));
	ldi_dev_end i_ldi_dev_end (.nrst_in(nrst_in), .lk(lk), .init_done_out(d_done),
		.power_state_out(pstate), .base_mode_out(base_q), .ext_mode_out(ext_q),
		.open_banks_out(banks));
	ldi_properties #(.STARTUP_WAIT_CYCLES(SW)) i_ldi_properties (.clk_in(clk_in),
		.nrst_in(nrst_in), .ck(lk.ck), .cke(lk.cke), .cs_n(lk.cs_n), .ras_n(lk.ras_n),
		.cas_n(lk.cas_n), .we_n(lk.we_n), .ba(lk.ba), .addr(lk.addr), .dm(lk.dm),
		.dq_c_oe_n(lk.dq_c_oe_n), .dqs_c_oe_n(lk.dqs_c_oe_n), .dq_d_oe_n(lk.dq_d_oe_n),
		.dqs_d_oe_n(lk.dqs_d_oe_n));

	task automatic tally_and_finish();
		if (fail_count == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Inputs always move 1 ns after the edge, away from sampling
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	function automatic logic seen(input int k, input logic [3:0] v);
		case (k)
			0: return cmd_ready_out;
			1: return c_done;
			2: return rdata_valid_out;
			default: return pstate == v;
		endcase
	endfunction

	task automatic wait_for(input int k, input logic [3:0] v, input int lim);
		int i;
		for (i = 0; i < lim && seen(k, v) !== 1'b1; i++)
			tick(1);
		chk("wait_for", 16'h0, {15'h0, i == lim});
		if (i == lim)
			tally_and_finish();
	endtask

	task automatic do_cmd(input ldi_cmd_t c, input logic [ADDR_W-1:0] a,
		input logic [DQ_W-1:0] d, input logic [LANES-1:0] m);
		cmd_in = c;
		addr_in = a;
		wdata_in = d;
		wmask_in = m;
		cmd_valid_in = 1'b1;
		wait_for(0, 4'h0, 100);
		tick(1);
		cmd_valid_in = 1'b0;
		tick(1);
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DQ_W-1:0] exp);
		do_cmd(CMD_READ, a, 16'h0, 2'h0);
		wait_for(2, 4'h0, 40);
		chk("rdata_out", exp, rdata_out);
	endtask

	initial begin
		// A real falling edge is needed to reach the async resets
		#1;
		nrst_in = 1'b0;
		tick(5);
		chk("cke", 16'h1, {15'h0, lk.cke});
		nrst_in = 1'b1;
		wait_for(1, 4'h0, 2000);
		// Device must be ready before the controller's first user slot
		tick(1);
		chk("dev_init_done", 16'h1, {15'h0, d_done});
		chk("base_mode", {2'h0, base_mode_in}, {2'h0, base_q});
		chk("ext_mode", {2'h0, ext_mode_in}, {2'h0, ext_q});
		chk("power_state", 16'h1, {12'h0, pstate});
		do_cmd(CMD_ACT, 14'h0010, 16'h0, 2'h0);
		chk("open_banks", 16'h1, {12'h0, banks});
		do_cmd(CMD_WRITE, 14'h0003, 16'ha5c3, 2'h0);
		do_cmd(CMD_WRITE, 14'h0004, 16'hffff, 2'h0);
		do_cmd(CMD_WRITE, 14'h0004, 16'h1234, 2'h2);
		do_cmd(4'hc, 14'h0003, 16'h0000, 2'h0);
		rd(14'h0003, 16'ha5c3);
		rd(14'h0004, 16'hff34);
		// Stopping ck is only legal once init is over
		clock_stop_in = 1'b1;
		tick(4);
		ck_seen = lk.ck;
		// Odd distance, so a running clock cannot match
		tick(5);
		chk("ck_stopped", {15'h0, ck_seen}, {15'h0, lk.ck});
		chk("ck_low", 16'h0, {15'h0, ck_seen});
		clock_stop_in = 1'b0;
		tick(4);
		user_cke_in = 1'b0;
		wait_for(3, 4'h4, 50);
		user_cke_in = 1'b1;
		wait_for(3, 4'h1, 50);
		do_cmd(CMD_PRE, ADDR_ALL_BANKS, 16'h0, 2'h0);
		user_cke_in = 1'b0;
		wait_for(3, 4'h2, 50);
		user_cke_in = 1'b1;
		wait_for(3, 4'h1, 50);
		user_cke_in = 1'b0;
		do_cmd(CMD_REF, 14'h0, 16'h0, 2'h0);
		wait_for(3, 4'h8, 50);
		user_cke_in = 1'b1;
		wait_for(3, 4'h1, 50);
		supply_good_in = 1'b0;
		tick(6);
		chk("init_done", 16'h0, {15'h0, c_done});
		chk("cke", 16'h1, {15'h0, lk.cke});
		base_mode_in = 14'h0022;
		supply_good_in = 1'b1;
		wait_for(1, 4'h0, 2000);
		chk("base_mode", 16'h0022, {2'h0, base_q});
		restart_in = 1'b1;
		tick(4);
		chk("init_done", 16'h0, {15'h0, c_done});
		restart_in = 1'b0;
		wait_for(1, 4'h0, 2000);
		tally_and_finish();
	end
endmodule
